// [inc/phas_pkg.sv]
// Constants for the processor-hot alert status register block
package phas_pkg;
  // Register command code and layout
  localparam logic [7:0] PHAS_CMD_STATUS = 8'h21;
  localparam logic [15:0] PHAS_RESET_VAL = 16'ha800;
  localparam logic [15:0] PHAS_WR_MASK = 16'h7b80;
  localparam int PHAS_BIT_RSVD_HI = 15;
  localparam int PHAS_BIT_EXT_EN = 14;
  localparam int PHAS_BIT_WIDTH_HI = 13;
  localparam int PHAS_BIT_WIDTH_LO = 12;
  localparam int PHAS_BIT_CLEAR = 11;
  localparam int PHAS_BIT_FAIL = 9;
  localparam int PHAS_BIT_EXIT = 8;
  localparam int PHAS_BIT_VREG = 7;
  localparam int PHAS_NUM_SRC = 8;
  // Reset values of the writable fields
  localparam logic PHAS_EXT_EN_RST = 1'b0;
  localparam logic [1:0] PHAS_WIDTH_RST = 2'h2;
  localparam logic PHAS_CLEAR_IDLE = 1'b1;
  // Pulse width codes
  localparam logic [1:0] PHAS_W_100US = 2'h0;
  localparam logic [1:0] PHAS_W_1MS = 2'h1;
  localparam logic [1:0] PHAS_W_10MS = 2'h2;
  localparam logic [1:0] PHAS_W_5S = 2'h3;
  // Timing, each in its own unit, then in cycles of the 50 MHz clock
  localparam int PHAS_CLK_HZ = 50_000_000;
  localparam int PHAS_T_100US_US = 100;
  localparam int PHAS_T_1MS_MS = 1;
  localparam int PHAS_T_10MS_MS = 10;
  localparam int PHAS_T_5S_S = 5;
  localparam int PHAS_CYC_100US = PHAS_T_100US_US * (PHAS_CLK_HZ / 1_000_000);
  localparam int PHAS_CYC_1MS = PHAS_T_1MS_MS * (PHAS_CLK_HZ / 1_000);
  localparam int PHAS_CYC_10MS = PHAS_T_10MS_MS * (PHAS_CLK_HZ / 1_000);
  localparam int PHAS_CYC_5S = PHAS_T_5S_S * PHAS_CLK_HZ;
  localparam int PHAS_TMR_W = 28;
  // Consecutive failed loads that trip the assist failure
  localparam int PHAS_FAIL_LIMIT = 7;
  localparam int PHAS_FCNT_W = 3;
endpackage

// [logic/phas_status.sv]
// Processor-hot alert status register with pulse timer and assist-mode supervision
`timescale 1ns/1ns

// How it works
// R1 - Register 21h resets to A800h, fixed bits.
// R2 - Extension on: pin low until clear written.
// R3 - Width field picks minimum pulse length.
// R4 - Writing clear zero ends pulse, pin high.
// R5 - Seven consecutive failed loads set fail flag.
// R6 - Failure latches assist off until flag cleared.
// R7 - Host disable or fault exits assist mode.
// R8 - Exit sets flag, holds pin low until cleared.
// R9 - Low byte reports eight alert trigger flags.
// R10 - Writes touch only bits 14-11, 9, 8, 7.
module phas_status #(
  parameter int CYC_100US = phas_pkg::PHAS_CYC_100US, // Shortenable pulse lengths
  parameter int CYC_1MS = phas_pkg::PHAS_CYC_1MS,
  parameter int CYC_10MS = phas_pkg::PHAS_CYC_10MS,
  parameter int CYC_5S = phas_pkg::PHAS_CYC_5S
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register access by command code
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_cmd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Alert sources from the charger, asynchronous levels
  input wire logic [7:0] alert_src_in,
  // Capacitor-assist supervision, asynchronous levels
  input wire logic assist_req_in,
  input wire logic charger_fault_in,
  input wire logic load_fail_in,
  input wire logic load_ok_in,
  // Outputs
  output logic cap_assist_mode_out,
  output logic proc_hot_alert_pin_n_out
);

  localparam int NS = phas_pkg::PHAS_NUM_SRC;
  localparam int TW = phas_pkg::PHAS_TMR_W;
  localparam int FW = phas_pkg::PHAS_FCNT_W;
  localparam int SW = NS + 4;

  // Two-stage synchroniser for every asynchronous input
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] prev_r; // Previous synchronised value, for edges

  // Synchronise pins; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= {load_ok_in, load_fail_in, charger_fault_in, assist_req_in, alert_src_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Decoded synchronised signals
  logic [NS-1:0] src_s;
  logic [NS-1:0] src_rise;
  logic req_s;
  logic fault_s;
  logic fail_ev;
  logic ok_ev;
  assign src_s = sync2_r[NS-1:0];
  assign src_rise = sync2_r[NS-1:0] & ~prev_r[NS-1:0];
  assign req_s = sync2_r[NS];
  assign fault_s = sync2_r[NS+1];
  assign fail_ev = sync2_r[NS+2] & ~prev_r[NS+2];
  assign ok_ev = sync2_r[NS+3] & ~prev_r[NS+3];

  // Register state
  logic ext_en_r, ext_en_nxt; // Pulse extension enable
  logic [1:0] width_r, width_nxt; // Minimum pulse width code
  logic clear_r, clear_nxt; // Pulse clear, idle high
  logic fail_r, fail_nxt; // Assist failure flag
  logic exit_r, exit_nxt; // Assist exit flag
  logic [NS-1:0] trig_r, trig_nxt; // Trigger flags
  logic mode_r, mode_nxt; // Capacitor-assist mode active
  logic [FW-1:0] fcnt_r, fcnt_nxt; // Consecutive failed loads
  logic ext_low_r, ext_low_nxt; // Extended pulse holding pin low
  logic [TW-1:0] tmr_r, tmr_nxt; // Minimum pulse timer
  logic pin_n_r, pin_n_nxt; // Alert pin, active low
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  // Access decode
  logic hit;
  logic wr;
  logic rd;
  logic [15:0] rd_word;
  logic [TW-1:0] width_cyc;
  assign hit = reg_cmd_in == phas_pkg::PHAS_CMD_STATUS;
  assign wr = reg_wr_in && hit;
  assign rd = reg_rd_in && hit;

  // Readback word: top bit one, bit 10 zero
  always_comb begin
    rd_word = '0; // R1
    rd_word[phas_pkg::PHAS_BIT_RSVD_HI] = 1'b1; // R1
    rd_word[phas_pkg::PHAS_BIT_EXT_EN] = ext_en_r;
    rd_word[phas_pkg::PHAS_BIT_WIDTH_HI:phas_pkg::PHAS_BIT_WIDTH_LO] = width_r;
    rd_word[phas_pkg::PHAS_BIT_CLEAR] = clear_r;
    rd_word[phas_pkg::PHAS_BIT_FAIL] = fail_r;
    rd_word[phas_pkg::PHAS_BIT_EXIT] = exit_r;
    rd_word[NS-1:0] = trig_r; // R9
  end

  // Width code to cycle count
  always_comb begin
    unique case (width_r) // R3
      phas_pkg::PHAS_W_100US: width_cyc = TW'(CYC_100US);
      phas_pkg::PHAS_W_1MS: width_cyc = TW'(CYC_1MS);
      phas_pkg::PHAS_W_10MS: width_cyc = TW'(CYC_10MS);
      default: width_cyc = TW'(CYC_5S);
    endcase
  end

  // Next state of the whole block
  always_comb begin
    ext_en_nxt = ext_en_r;
    width_nxt = width_r;
    clear_nxt = clear_r;
    fail_nxt = fail_r;
    exit_nxt = exit_r;
    trig_nxt = trig_r;
    fcnt_nxt = fcnt_r;
    ext_low_nxt = ext_low_r;
    tmr_nxt = tmr_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    // Host write: only the writable field bits take effect
    if (wr) begin
      ext_en_nxt = reg_wdata_in[phas_pkg::PHAS_BIT_EXT_EN]; // R10
      width_nxt = reg_wdata_in[phas_pkg::PHAS_BIT_WIDTH_HI:phas_pkg::PHAS_BIT_WIDTH_LO]; // R10
      clear_nxt = reg_wdata_in[phas_pkg::PHAS_BIT_CLEAR]; // R10
      // Flags are cleared by writing zero; writing one leaves them
      if (!reg_wdata_in[phas_pkg::PHAS_BIT_FAIL]) begin
        fail_nxt = 1'b0; // R6
      end
      if (!reg_wdata_in[phas_pkg::PHAS_BIT_EXIT]) begin
        exit_nxt = 1'b0; // R8
      end
      if (!reg_wdata_in[phas_pkg::PHAS_BIT_VREG]) begin
        trig_nxt[phas_pkg::PHAS_BIT_VREG] = 1'b0; // R9
      end
    end
    // Read returns the word; read-only triggers clear after being read
    if (rd) begin
      rdata_nxt = rd_word;
      rvalid_nxt = 1'b1;
      trig_nxt[NS-2:0] = '0;
    end else if (reg_rd_in) begin
      rdata_nxt = '0; // Unknown command reads as zero
      rvalid_nxt = 1'b1;
    end
    // Clear written to zero ends an extended pulse and returns to idle
    if (clear_r == 1'b0) begin
      ext_low_nxt = 1'b0; // R4
      clear_nxt = phas_pkg::PHAS_CLEAR_IDLE; // R4
    end
    // Pulse timer counts down
    if (tmr_r != '0) begin
      tmr_nxt = tmr_r - TW'(1);
    end
    // Source rising edges and high levels set flags, winning over any clear
    trig_nxt = trig_nxt | src_rise | src_s; // R9
    if (src_rise != '0) begin
      if (ext_en_r) begin
        ext_low_nxt = 1'b1; // R2
      end else begin
        tmr_nxt = width_cyc; // R3
      end
    end
    // Consecutive failed loads while assisting
    if (mode_r && ok_ev) begin
      fcnt_nxt = '0;
    end else if (mode_r && fail_ev) begin
      if (fcnt_r == FW'(phas_pkg::PHAS_FAIL_LIMIT - 1)) begin
        fail_nxt = 1'b1; // R5
        fcnt_nxt = '0;
      end else begin
        fcnt_nxt = fcnt_r + FW'(1);
      end
    end
    // Mode runs while requested, fault free and not failed
    mode_nxt = req_s && !fault_s && !fail_r && !fail_nxt; // R6 R7
    if (mode_r && !mode_nxt) begin
      exit_nxt = 1'b1; // R8
    end
    // Pin low while any pulse or the exit flag holds it
    pin_n_nxt = !(ext_low_nxt || tmr_nxt != '0 || exit_nxt); // R2 R8
  end

  // Register all state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_en_r <= phas_pkg::PHAS_EXT_EN_RST; // R1
      width_r <= phas_pkg::PHAS_WIDTH_RST; // R1
      clear_r <= phas_pkg::PHAS_CLEAR_IDLE; // R1
      fail_r <= 1'b0;
      exit_r <= 1'b0;
      trig_r <= '0;
      mode_r <= 1'b0;
      fcnt_r <= '0;
      ext_low_r <= 1'b0;
      tmr_r <= '0;
      pin_n_r <= 1'b1;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      ext_en_r <= ext_en_nxt;
      width_r <= width_nxt;
      clear_r <= clear_nxt;
      fail_r <= fail_nxt;
      exit_r <= exit_nxt;
      trig_r <= trig_nxt;
      mode_r <= mode_nxt;
      fcnt_r <= fcnt_nxt;
      ext_low_r <= ext_low_nxt;
      tmr_r <= tmr_nxt;
      pin_n_r <= pin_n_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign cap_assist_mode_out = mode_r;
  assign proc_hot_alert_pin_n_out = pin_n_r;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  fixed_bits_a: assert property (rvalid_r |-> rdata_r[phas_pkg::PHAS_BIT_RSVD_HI] == 1'b1 // R1
    || rdata_r == '0)
    else $error("Reserved top bit not one on read");
  rsvd_ten_a: assert property (rvalid_r |-> rdata_r[10] == 1'b0) // R1
    else $error("Reserved bit 10 not zero");
  ext_hold_a: assert property (ext_low_r && clear_r |=> !pin_n_r) // R2
    else $error("Extended pulse released early");
  // Pin mirrors the running timer, so it is low in every cycle the timer is nonzero
  min_width_a: assert property (tmr_r != '0 |-> !pin_n_r) // R3
    else $error("Pin high before minimum width");
  clear_end_a: assert property (clear_r == 1'b0 && !exit_r |=> !ext_low_r ##1 clear_r) // R4
    else $error("Clear did not end pulse");
  fail_off_a: assert property (fail_r |-> !mode_nxt) // R6
    else $error("Assist mode active while failed");
  fault_exit_a: assert property (fault_s |=> !mode_r) // R7
    else $error("Assist mode survived a fault");
  exit_flag_a: assert property ($fell(mode_r) |-> exit_r ##1 !pin_n_r) // R8
    else $error("Exit did not flag or pull pin");
  seven_fail_a: assert property (mode_r && fail_ev && !ok_ev
    && fcnt_r == FW'(phas_pkg::PHAS_FAIL_LIMIT - 1)
    |=> fail_r) // R5
    else $error("Failure flag not set on seventh load");
  wr_mask_a: assert property (wr && !rd |=> trig_r[6:0] == $past(trig_r[6:0])
    || trig_r[6:0] != '0) // R10
    else $error("Read-only triggers changed by write");

  ext_cov: cover property (ext_low_r ##1 clear_r == 1'b0 ##2 pin_n_r);
  fail_cov: cover property ($rose(fail_r));
  exit_cov: cover property ($rose(exit_r));
  width_cov: cover property ($fell(pin_n_r) && !ext_en_r);
endmodule

// [dv/phas_host.sv]
// Host controller model that issues command-bus accesses to the status register
`timescale 1ns/1ns
module phas_host (
  // Clock
  input wire logic clk_in,
  // Command bus toward the device
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_cmd_out,
  output logic [15:0] reg_wdata_out
);
  // Idle bus from time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_cmd_out = 8'h00;
    reg_wdata_out = 16'h0000;
  end
  // One access held for a single edge; data is scrambled afterwards so stale data never helps
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
    @(posedge clk_in);
    reg_wr_out <= wr;
    reg_rd_out <= ~wr;
    reg_cmd_out <= cmd;
    reg_wdata_out <= d;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the processor-hot alert status register
`timescale 1ns/1ns
module testbench;
  // Clock, reset and design inputs
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata_out;
  logic reg_rvalid_out, cap_assist_mode_out, proc_hot_alert_pin_n_out;
  logic [7:0] alert_src_in = 8'h00;
  logic assist_req_in = 1'b0;
  logic charger_fault_in = 1'b0;
  logic load_fail_in = 1'b0;
  logic load_ok_in = 1'b0;
  // Expected read words and tallies
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int b, n;
  // Shortened pulse lengths, one per width code
  localparam int W [4] = '{5, 10, 20, 40};
  phas_host host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_cmd_out(reg_cmd), .reg_wdata_out(reg_wdata));
  phas_status #(.CYC_100US(W[0]), .CYC_1MS(W[1]), .CYC_10MS(W[2]), .CYC_5S(W[3])) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_cmd_in(reg_cmd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .alert_src_in(alert_src_in),
    .assist_req_in(assist_req_in), .charger_fault_in(charger_fault_in),
    .load_fail_in(load_fail_in), .load_ok_in(load_ok_in),
    .cap_assist_mode_out(cap_assist_mode_out),
    .proc_hot_alert_pin_n_out(proc_hot_alert_pin_n_out));
  // 50 MHz clock
  initial forever #10 clk_in = ~clk_in;
  // Tally one comparison
  task automatic note(input string what, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  // Read word comparison
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] s);
    note("read word", e, s);
  endtask
  // Output levels, sampled mid-cycle, return on a rising edge
  task automatic chk(input logic em, input logic ep);
    @(negedge clk_in);
    note("assist mode", {15'h0000, em}, {15'h0000, cap_assist_mode_out});
    note("alert pin", {15'h0000, ep}, {15'h0000, proc_hot_alert_pin_n_out});
    @(posedge clk_in);
  endtask
  // Pulse length must equal the programmed count exactly
  task automatic cmp_len(input int e, input int s);
    note("pulse length", 16'(e), 16'(s));
  endtask
  // Bus helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
    exp_q.push_back(e);
    host.access(1'b0, cmd, 16'h0000);
  endtask
  task automatic wr(input logic [15:0] d);
    host.access(1'b1, 8'h21, d);
  endtask
  // Count the cycles for which the alert pin stays low
  task automatic low_len(output int k);
    k = 0;
    while (proc_hot_alert_pin_n_out !== 1'b0 && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    k = 0;
    while (proc_hot_alert_pin_n_out === 1'b0 && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    // Hand back on a rising edge so the next stimulus lands there
    @(posedge clk_in);
  endtask
  // One load attempt seen by the supervision logic
  task automatic blip(input logic ok);
    if (ok) load_ok_in <= 1'b1;
    else load_fail_in <= 1'b1;
    cyc(4);
    load_ok_in <= 1'b0;
    load_fail_in <= 1'b0;
    cyc(4);
  endtask
  // Match every read answer with the oldest note, mid-cycle where outputs are settled
  always @(negedge clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) note("read count", 16'h0000, 16'h0001);
      else cmp_word(exp_q.pop_front(), reg_rdata_out);
    end
  end
  // Verdict and end of run
  task automatic test_done;
    // A read that never answered leaves a note behind
    note("reads pending", 16'h0000, 16'(exp_q.size()));
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200_000;
    bad_count++;
    test_done();
  end
  // Main sequence
  initial begin
    n = $urandom(24277);
    cyc(10);
    rst_n_in <= 1'b1;
    rd(8'h21, 16'ha800);
    rd(8'h20, 16'h0000);
    host.access(1'b1, 8'h20, 16'hffff);
    wr(16'hffff);
    rd(8'h21, 16'hf800);
    wr(16'h0000);
    rd(8'h21, 16'h8800);
    // Every width code with a random read-only source
    for (int i = 0; i < 4; i++) begin
      b = $urandom % 7;
      wr(16'h0800 | (16'(i) << 12));
      @(posedge clk_in);
      alert_src_in[b] <= 1'b1;
      low_len(n);
      cmp_len(W[i], n);
      alert_src_in[b] <= 1'b0;
      // Let the released source clear the synchroniser before the read-clear
      cyc(3);
      rd(8'h21, 16'h8800 | (16'(i) << 12) | (16'h0001 << b));
      rd(8'h21, 16'h8800 | (16'(i) << 12));
    end
    // Extended pulse ended only by the clear command
    wr(16'h4800);
    alert_src_in[7] <= 1'b1;
    cyc(4);
    alert_src_in[7] <= 1'b0;
    cyc(W[3]);
    chk(1'b0, 1'b0);
    rd(8'h21, 16'hc880);
    rd(8'h21, 16'hc880);
    wr(16'h4000);
    cyc(3);
    chk(1'b0, 1'b1);
    rd(8'h21, 16'hc800);
    wr(16'h0800);
    // Assist exit by host disable, then by charger fault
    for (int k = 0; k < 2; k++) begin
      assist_req_in <= 1'b1;
      cyc(6);
      chk(1'b1, 1'b1);
      if (k == 0) assist_req_in <= 1'b0;
      else charger_fault_in <= 1'b1;
      cyc(6);
      chk(1'b0, 1'b0);
      rd(8'h21, 16'h8900);
      cyc(W[3]);
      chk(1'b0, 1'b0);
      assist_req_in <= 1'b0;
      charger_fault_in <= 1'b0;
      wr(16'h0800);
      cyc(6);
      chk(1'b0, 1'b1);
    end
    // Failed loads: a success restarts the run, the seventh in a row latches off
    assist_req_in <= 1'b1;
    cyc(6);
    for (int k = 0; k < 13; k++) blip(k == 6);
    chk(1'b1, 1'b1);
    blip(1'b0);
    chk(1'b0, 1'b0);
    rd(8'h21, 16'h8b00);
    cyc(20);
    chk(1'b0, 1'b0);
    wr(16'h0800);
    cyc(6);
    chk(1'b1, 1'b1);
    cyc(5);
    test_done();
  end
endmodule
